// ===== include/sacc_defs.vh
// Purpose: shared constants of the successive-approximation converter control
// Assumes: included by its bare name from every design file of the block
// Notes: offsets are byte addresses on the AXI4-Lite register bus
`ifndef SACC_DEFS_VH
`define SACC_DEFS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SACC_ADDR_W 8
`define SACC_OFF_CTRL 8'h00
`define SACC_OFF_CHAN 8'h04
`define SACC_OFF_RANGE 8'h08
`define SACC_OFF_UPPER 8'h0c
`define SACC_OFF_LOWER 8'h10
`define SACC_OFF_RESF 8'h14
`define SACC_OFF_RESN 8'h18
`define SACC_OFF_STAT 8'h1c

// decoded register indices
`define SACC_IDX_CTRL 4'h0
`define SACC_IDX_CHAN 4'h1
`define SACC_IDX_RANGE 4'h2
`define SACC_IDX_UPPER 4'h3
`define SACC_IDX_LOWER 4'h4
`define SACC_IDX_RESF 4'h5
`define SACC_IDX_RESN 4'h6
`define SACC_IDX_STAT 4'h7
`define SACC_IDX_NONE 4'hf

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define SACC_CTRL_EN 0
`define SACC_CTRL_RUN 1
`define SACC_CTRL_SEQ 2
`define SACC_CTRL_HWT 3
`define SACC_STAT_BUSY 0
`define SACC_STAT_HOLD 1
`define SACC_STAT_STABLE 2
`define SACC_CHAN_W 5
`define SACC_RES_W 10
`define SACC_NARROW_W 8

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define SACC_CHAN_RST 5'h00
`define SACC_UPPER_RST 8'hff
`define SACC_LOWER_RST 8'h00
`define SACC_RESP_OKAY 2'h0
`define SACC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SACC_CLK_MHZ 250
`define SACC_STAB_NS 1000
`define SACC_STAB_CYC ((`SACC_STAB_NS * `SACC_CLK_MHZ + 999) / 1000)
`define SACC_SAMPLE_CYC 8
`define SACC_BIT_CYC 6

`endif

// ===== hw/sacc_sar.v
// Purpose: bit-decision engine, one approximation bit per step
// Assumes: comp_ge is already synchronised to aclk
// Notes: abort wins over start; done_ff pulses one cycle with result_ff
`include "sacc_defs.vh"

module sacc_sar #(
	parameter RES_W = `SACC_RES_W,
	parameter BIT_CYCLES = `SACC_BIT_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire start,
	input wire abort,
	input wire comp_ge,
	output reg [RES_W-1:0] trial_ff,
	output reg busy_ff,
	output reg done_ff,
	output reg [RES_W-1:0] result_ff
);

// ----------------------------------------------------------------
// step bookkeeping
// ----------------------------------------------------------------
localparam [3:0] CNT_LAST = BIT_CYCLES[3:0] - 4'h1;
localparam [3:0] TOP_BIT = RES_W[3:0] - 4'h1;
localparam [RES_W-1:0] ONE = {{(RES_W-1){1'b0}}, 1'b1};
localparam [RES_W-1:0] MSB = ONE << TOP_BIT;

reg [3:0] bit_ff;
reg [3:0] cnt_ff;

// mask of the bit under test and of the next lower one
wire [RES_W-1:0] bit_mask = ONE << bit_ff;
wire [RES_W-1:0] next_mask = bit_mask >> 1;
// keep bit when held input >= tap
wire [RES_W-1:0] decided = comp_ge ? trial_ff : (trial_ff & ~bit_mask);

// successive approximation sequencer
always @(posedge aclk) begin
	if (!aresetn) begin
		trial_ff <= {RES_W{1'b0}};
		busy_ff <= 1'b0;
		done_ff <= 1'b0;
		result_ff <= {RES_W{1'b0}};
		bit_ff <= 4'h0;
		cnt_ff <= 4'h0;
	end else begin
		done_ff <= 1'b0;
		if (abort) begin
			// partial value is thrown away
			busy_ff <= 1'b0;
			trial_ff <= {RES_W{1'b0}};
		end else if (start) begin
			// msb set, tap at half reference
			trial_ff <= MSB;
			bit_ff <= TOP_BIT;
			cnt_ff <= 4'h0;
			busy_ff <= 1'b1;
		end else if (busy_ff) begin
			if (cnt_ff != CNT_LAST) begin
				cnt_ff <= cnt_ff + 4'h1;
			end else begin
				cnt_ff <= 4'h0;
				if (bit_ff == 4'h0) begin
					result_ff <= decided;
					done_ff <= 1'b1;
					busy_ff <= 1'b0;
					trial_ff <= decided;
				end else begin
					// next bit trial from decided bits
					trial_ff <= decided | next_mask;
					bit_ff <= bit_ff - 4'h1;
				end
			end
		end
	end
end

endmodule // sacc_sar

// ===== hw/sacc_top.v
// Purpose: conversion control of a 10-bit successive-approximation converter
// Assumes: analog sample-hold, tap selector and comparator outside the block
// Notes: registers reached over AXI4-Lite; comparator and trigger are pins
//
// Overview of operation
// - sample channel, then hold until conversion done
// - start with msb set, half-reference tap
// - keep msb if input at or above tap
// - next bit set, tap from decided bits
// - bit kept when held input at or above
// - after ten bits store result, raise interrupt
// - sequential mode repeats conversions while run flag set
// - out-of-window result: no store, no interrupt
// - sequential or hardware no-wait keeps run flag
// - 10-bit full and 8-bit narrow results
// - enabling from stop enters conversion standby
// - software run flag converts selected channel
// - software one-shot end clears run, standby
// - run rewrite during conversion restarts it
// - channel write during conversion restarts it
// - run clear during conversion goes standby
// - enable clear in standby goes stop
// - run write ignored while converter disabled
// - software mode ignores hardware trigger in standby
`include "sacc_defs.vh"

module sacc_top #(
	parameter SAMPLE_CYCLES = `SACC_SAMPLE_CYC,
	parameter BIT_CYCLES = `SACC_BIT_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire [`SACC_ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`SACC_ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire comparator_ge,
	input wire hw_trigger,
	output reg hold_ff,
	output wire [`SACC_RES_W-1:0] tap_code,
	output reg [`SACC_CHAN_W-1:0] channel_select_ff,
	output reg conversion_done_irq_ff
);

// ----------------------------------------------------------------
// constants and helpers
// ----------------------------------------------------------------
localparam [3:0] ST_STOP = 4'h1;
localparam [3:0] ST_STBY = 4'h2;
localparam [3:0] ST_SAMP = 4'h4;
localparam [3:0] ST_CONV = 4'h8;
localparam [7:0] SAMP_LAST = SAMPLE_CYCLES[7:0] - 8'h1;
localparam integer STAB_CYC = `SACC_STAB_CYC;
localparam [8:0] STAB_LAST = STAB_CYC[8:0];
localparam RW = `SACC_RES_W;
localparam NW = `SACC_NARROW_W;

// map a byte address to a register index
function [3:0] dec_addr;
	input [`SACC_ADDR_W-1:0] a;
	begin
		case (a)
			`SACC_OFF_CTRL: dec_addr = `SACC_IDX_CTRL;
			`SACC_OFF_CHAN: dec_addr = `SACC_IDX_CHAN;
			`SACC_OFF_RANGE: dec_addr = `SACC_IDX_RANGE;
			`SACC_OFF_UPPER: dec_addr = `SACC_IDX_UPPER;
			`SACC_OFF_LOWER: dec_addr = `SACC_IDX_LOWER;
			`SACC_OFF_RESF: dec_addr = `SACC_IDX_RESF;
			`SACC_OFF_RESN: dec_addr = `SACC_IDX_RESN;
			`SACC_OFF_STAT: dec_addr = `SACC_IDX_STAT;
			default: dec_addr = `SACC_IDX_NONE;
		endcase
	end
endfunction

// window test on the narrow result; sel inverts the window
function in_window;
	input [NW-1:0] val;
	input [NW-1:0] lo;
	input [NW-1:0] hi;
	input sel;
	reg in_range;
	begin
		in_range = (val >= lo) && (val <= hi);
		in_window = sel ? ~in_range : in_range;
	end
endfunction

// ----------------------------------------------------------------
// state and register storage
// ----------------------------------------------------------------
reg [3:0] state_ff;
reg [3:0] nxt_state;
reg en_ff;
reg run_ff;
reg nxt_run;
reg seq_ff;
reg hwt_ff;
reg range_sel_ff;
reg [NW-1:0] upper_ff;
reg [NW-1:0] lower_ff;
reg [RW-1:0] res_full_ff;
reg [NW-1:0] res_narrow_ff;
reg [7:0] samp_cnt_ff;
reg [8:0] stab_cnt_ff;
reg stable_ff;
reg [2:0] comp_sync_ff;
reg [2:0] trig_sync_ff;
reg comp_ff;
reg trig_ff;
reg trig_prev_ff;
reg [`SACC_ADDR_W-1:0] aw_addr_ff;
reg aw_full_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
reg w_full_ff;
reg [31:0] nxt_rdata;
reg [1:0] nxt_rresp;
wire sar_busy;
wire sar_done;
wire [RW-1:0] sar_result;

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
// three stages; a new level counts once stages two and three agree
always @(posedge aclk) begin
	if (!aresetn) begin
		comp_sync_ff <= 3'h0;
		trig_sync_ff <= 3'h0;
		comp_ff <= 1'b0;
		trig_ff <= 1'b0;
		trig_prev_ff <= 1'b0;
	end else begin
		comp_sync_ff <= {comp_sync_ff[1:0], comparator_ge};
		trig_sync_ff <= {trig_sync_ff[1:0], hw_trigger};
		if (comp_sync_ff[1] == comp_sync_ff[2])
			comp_ff <= comp_sync_ff[2];
		if (trig_sync_ff[1] == trig_sync_ff[2])
			trig_ff <= trig_sync_ff[2];
		trig_prev_ff <= trig_ff;
	end
end

wire trig_rise = trig_ff & ~trig_prev_ff;

// ----------------------------------------------------------------
// AXI4-Lite slave handshakes
// ----------------------------------------------------------------
wire aw_take = s_axi_awvalid & s_axi_awready;
wire w_take = s_axi_wvalid & s_axi_wready;
wire ar_take = s_axi_arvalid & s_axi_arready;
wire do_write = aw_full_ff & w_full_ff & ~s_axi_bvalid;
wire nxt_aw_full = (aw_full_ff | aw_take) & ~do_write;
wire nxt_w_full = (w_full_ff | w_take) & ~do_write;
wire nxt_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
wire [3:0] wr_idx = dec_addr(aw_addr_ff);
wire wr_lane0 = do_write & wstrb_ff[0];

// address and data may arrive in either order; response follows both
always @(posedge aclk) begin
	if (!aresetn) begin
		aw_addr_ff <= {`SACC_ADDR_W{1'b0}};
		aw_full_ff <= 1'b0;
		wdata_ff <= 32'h0;
		wstrb_ff <= 4'h0;
		w_full_ff <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `SACC_RESP_OKAY;
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0;
		s_axi_rresp <= `SACC_RESP_OKAY;
	end else begin
		if (aw_take)
			aw_addr_ff <= s_axi_awaddr;
		if (w_take) begin
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end
		aw_full_ff <= nxt_aw_full;
		w_full_ff <= nxt_w_full;
		s_axi_awready <= ~nxt_aw_full;
		s_axi_wready <= ~nxt_w_full;
		if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_idx == `SACC_IDX_NONE) ?
				`SACC_RESP_SLVERR : `SACC_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		s_axi_rvalid <= nxt_rvalid;
		s_axi_arready <= ~nxt_rvalid;
		if (ar_take) begin
			s_axi_rdata <= nxt_rdata;
			s_axi_rresp <= nxt_rresp;
		end
	end
end

// read data mux; unmapped addresses answer with a slave error
always @* begin
	nxt_rdata = 32'h0;
	nxt_rresp = `SACC_RESP_OKAY;
	case (dec_addr(s_axi_araddr))
		`SACC_IDX_CTRL: nxt_rdata = {28'h0, hwt_ff, seq_ff, run_ff, en_ff};
		`SACC_IDX_CHAN: nxt_rdata = {27'h0, channel_select_ff};
		`SACC_IDX_RANGE: nxt_rdata = {31'h0, range_sel_ff};
		`SACC_IDX_UPPER: nxt_rdata = {24'h0, upper_ff};
		`SACC_IDX_LOWER: nxt_rdata = {24'h0, lower_ff};
		// full-width result in the low 10 bits
		`SACC_IDX_RESF: nxt_rdata = {22'h0, res_full_ff};
		`SACC_IDX_RESN: nxt_rdata = {24'h0, res_narrow_ff};
		`SACC_IDX_STAT: nxt_rdata = {24'h0, state_ff, 1'b0, stable_ff,
			hold_ff, sar_busy};
		default: nxt_rresp = `SACC_RESP_SLVERR;
	endcase
end

// ----------------------------------------------------------------
// control register writes
// ----------------------------------------------------------------
wire wr_ctrl = wr_lane0 & (wr_idx == `SACC_IDX_CTRL);
wire wr_chan = wr_lane0 & (wr_idx == `SACC_IDX_CHAN);
wire wd_en = wdata_ff[`SACC_CTRL_EN];
wire wd_run = wdata_ff[`SACC_CTRL_RUN];
// run write needs the converter already enabled
wire wr_run1 = wr_ctrl & wd_run & en_ff;
wire wr_run0 = wr_ctrl & ~wd_run;
wire nxt_en = wr_ctrl ? wd_en : en_ff;
wire active = (state_ff == ST_SAMP) | (state_ff == ST_CONV);
wire kill = active & (~en_ff | ~run_ff);
wire restart = active & ~kill & (wr_run1 | wr_chan);
wire samp_end = (state_ff == ST_SAMP) & ~kill & ~restart &
	(samp_cnt_ff == SAMP_LAST);
wire sar_start = samp_end;
wire sar_abort = (state_ff == ST_CONV) & ~sar_done & (kill | restart);
wire [NW-1:0] res_narrow = sar_result[RW-1:RW-NW];
// store only inside the programmed window, or only outside it when range_sel_ff is set
wire store_ok = sar_done &
	in_window(res_narrow, lower_ff, upper_ff, range_sel_ff);
wire auto_clear = sar_done & ~seq_ff & ~hwt_ff;

// configuration registers
always @(posedge aclk) begin
	if (!aresetn) begin
		en_ff <= 1'b0;
		seq_ff <= 1'b0;
		hwt_ff <= 1'b0;
		range_sel_ff <= 1'b0;
		upper_ff <= `SACC_UPPER_RST;
		lower_ff <= `SACC_LOWER_RST;
		channel_select_ff <= `SACC_CHAN_RST;
	end else begin
		if (wr_ctrl) begin
			en_ff <= wd_en;
			seq_ff <= wdata_ff[`SACC_CTRL_SEQ];
			hwt_ff <= wdata_ff[`SACC_CTRL_HWT];
		end
		if (wr_chan)
			channel_select_ff <= wdata_ff[`SACC_CHAN_W-1:0];
		if (wr_lane0 & (wr_idx == `SACC_IDX_RANGE))
			range_sel_ff <= wdata_ff[0];
		if (wr_lane0 & (wr_idx == `SACC_IDX_UPPER))
			upper_ff <= wdata_ff[NW-1:0];
		if (wr_lane0 & (wr_idx == `SACC_IDX_LOWER))
			lower_ff <= wdata_ff[NW-1:0];
	end
end

// run flag: software set wins over the automatic clear
always @* begin
	nxt_run = run_ff;
	if (auto_clear)
		nxt_run = 1'b0;
	if (wr_run0)
		nxt_run = 1'b0;
	if (wr_run1)
		nxt_run = 1'b1;
	if (~nxt_en)
		nxt_run = 1'b0;
end

// ----------------------------------------------------------------
// conversion sequencer
// ----------------------------------------------------------------
always @* begin
	nxt_state = state_ff;
	case (state_ff)
		ST_STOP: begin
			if (en_ff)
				nxt_state = ST_STBY;
		end
		ST_STBY: begin
			if (~en_ff)
				nxt_state = ST_STOP;
			// trigger only counts in hardware mode
			else if (run_ff & (~hwt_ff | trig_rise))
				nxt_state = ST_SAMP;
		end
		ST_SAMP: begin
			if (kill)
				nxt_state = en_ff ? ST_STBY : ST_STOP;
			else if (samp_end)
				nxt_state = ST_CONV;
		end
		ST_CONV: begin
			if (sar_done) begin
				if (seq_ff | restart | (wr_run1 & auto_clear))
					nxt_state = ST_SAMP;
				else
					nxt_state = ST_STBY;
			end else if (kill)
				nxt_state = en_ff ? ST_STBY : ST_STOP;
			else if (restart)
				nxt_state = ST_SAMP;
		end
		default: nxt_state = ST_STOP;
	endcase
end

// state, run flag, sampling counter and sample-hold control
always @(posedge aclk) begin
	if (!aresetn) begin
		state_ff <= ST_STOP;
		run_ff <= 1'b0;
		samp_cnt_ff <= 8'h0;
		hold_ff <= 1'b0;
	end else begin
		state_ff <= nxt_state;
		run_ff <= nxt_run;
		if ((state_ff != ST_SAMP) | restart | samp_end)
			samp_cnt_ff <= 8'h0;
		else
			samp_cnt_ff <= samp_cnt_ff + 8'h1;
		// hold from sampling end to conversion end
		if (samp_end)
			hold_ff <= 1'b1;
		else if (nxt_state != ST_CONV)
			hold_ff <= 1'b0;
	end
end

// ----------------------------------------------------------------
// result store and completion pulse
// ----------------------------------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		res_full_ff <= {RW{1'b0}};
		res_narrow_ff <= {NW{1'b0}};
		conversion_done_irq_ff <= 1'b0;
	end else begin
		// results held until next good store
		conversion_done_irq_ff <= store_ok;
		if (store_ok) begin
			res_full_ff <= sar_result;
			res_narrow_ff <= res_narrow;
		end
	end
end

// ----------------------------------------------------------------
// stabilization indicator
// ----------------------------------------------------------------
// shows when software may set the run flag
always @(posedge aclk) begin
	if (!aresetn) begin
		stab_cnt_ff <= 9'h0;
		stable_ff <= 1'b0;
	end else if (~en_ff) begin
		stab_cnt_ff <= 9'h0;
		stable_ff <= 1'b0;
	end else if (stab_cnt_ff != STAB_LAST) begin
		stab_cnt_ff <= stab_cnt_ff + 9'h1;
	end else begin
		stable_ff <= 1'b1;
	end
end

// ----------------------------------------------------------------
// bit-decision engine
// ----------------------------------------------------------------
sacc_sar #(
	.RES_W(RW),
	.BIT_CYCLES(BIT_CYCLES)
) u_sar (
	.aclk(aclk),
	.aresetn(aresetn),
	.start(sar_start),
	.abort(sar_abort),
	.comp_ge(comp_ff),
	.trial_ff(tap_code),
	.busy_ff(sar_busy),
	.done_ff(sar_done),
	.result_ff(sar_result)
);

endmodule // sacc_top

// ===== sim/sacc_chk_chk.sv
// Purpose: port assertions for the converter control
// Assumes: bound to sacc_top, default parameters
// Notes: bit steps are judged against the previous trial value
`include "sacc_defs.vh"

module sacc_chk #(
	parameter SAMPLE_CYCLES = 8,
	parameter BIT_CYCLES = 6
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire comparator_ge,
	input wire hold_ff,
	input wire [`SACC_RES_W-1:0] tap_code,
	input wire conversion_done_irq_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BITS_LO = 10 * BIT_CYCLES - 1;
	localparam int BITS_HI = 10 * BIT_CYCLES + 1;
	logic [9:0] tap_prev_ff;
	logic hold_prev_ff;
	logic [7:0] hold_len_ff;
	logic [7:0] nxt_hold_len;
	wire [9:0] low_m = tap_prev_ff & (~tap_prev_ff + 10'h001);

	// length of the latest hold span, frozen once it ends
	always @* begin
		nxt_hold_len = hold_len_ff;
		if (hold_ff && !hold_prev_ff)
			nxt_hold_len = 8'h01;
		else if (hold_ff && hold_len_ff != 8'hff)
			nxt_hold_len = hold_len_ff + 8'h01;
	end

	// previous trial value and hold level
	always @(posedge aclk) begin
		if (!aresetn) begin
			tap_prev_ff <= 10'h000;
			hold_prev_ff <= 1'b0;
			hold_len_ff <= 8'h00;
		end else begin
			tap_prev_ff <= tap_code;
			hold_prev_ff <= hold_ff;
			hold_len_ff <= nxt_hold_len;
		end
	end

	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence hold_start;
		!hold_ff ##1 hold_ff;
	endsequence
	sequence step_move;
		hold_ff && hold_prev_ff && tap_code != tap_prev_ff &&
			tap_code != 10'h000 && low_m > 10'h001;
	endsequence

	hold_keep_a: assert property (hold_start |-> hold_ff[*8])
		else $error("hold dropped early");
	sample_first_a: assert property ($rose(hold_ff) |-> !$past(hold_ff, 8))
		else $error("sampling too short");
	tap_msb_a: assert property (hold_start |-> ##[0:2] tap_code == 10'h200)
		else $error("first tap not half");
	next_bit_a: assert property (step_move |->
		(tap_code & ~low_m) == ((tap_prev_ff & ~low_m) | (low_m >> 1)))
		else $error("next trial bit wrong");
	decide_bit_a: assert property (step_move |->
		((tap_code & low_m) != 10'h000) == $past(comparator_ge))
		else $error("bit decision wrong");
	done_pulse_a: assert property (conversion_done_irq_ff |=>
		!conversion_done_irq_ff)
		else $error("done longer than one cycle");
	done_bits_a: assert property ($rose(conversion_done_irq_ff) |->
		hold_len_ff >= BITS_LO && hold_len_ff <= BITS_HI)
		else $error("done without ten bit steps");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("read answer late");
endmodule // sacc_chk

bind sacc_top sacc_chk #(
	.SAMPLE_CYCLES(SAMPLE_CYCLES),
	.BIT_CYCLES(BIT_CYCLES)
) sacc_chk_i (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.comparator_ge(comparator_ge),
	.hold_ff(hold_ff),
	.tap_code(tap_code),
	.conversion_done_irq_ff(conversion_done_irq_ff)
);

// ===== sim/sacc_afe_model.sv
// Purpose: sample-hold, tap and comparator front end
// Assumes: level[] is set by the bench per channel
// Notes: slow adds one cycle of comparator lag
module sacc_afe_model (
	input wire aclk,
	input wire hold_ff,
	input wire [9:0] tap_code,
	input wire [4:0] channel_select_ff,
	input wire slow,
	output logic comparator_ge
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] level [0:31];
	logic [9:0] held;
	logic late;
	logic toggle;

	initial begin
		toggle = 1'b0;
		held = 10'h000;
		late = 1'b0;
		for (int i = 0; i < 32; i++)
			level[i] = 10'h000;
	end

	// track while sampling, freeze on hold
	always @(posedge aclk) begin
		toggle <= ~toggle;
		if (!hold_ff)
			held <= level[channel_select_ff];
		late <= (held >= tap_code);
	end

	always_comb comparator_ge = !hold_ff ? toggle :
		(slow ? late : held >= tap_code); // meaningless outside hold
endmodule // sacc_afe_model

// ===== sim/sacc_tb.sv
// Purpose: register-level tests of the converter control
// Assumes: register map of sacc_defs.vh, default timing
// Notes: results are exact since the front end holds whole codes
`include "sacc_defs.vh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, hw_trigger, hold, irq, cmp, slow;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [9:0] tap;
	logic [4:0] chan;
	int error_cnt = 0;
	int comparisons = 0;
	int irq_cnt = 0;
	int c0;

	sacc_top sacc_top_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .comparator_ge(cmp),
		.hw_trigger(hw_trigger), .hold_ff(hold), .tap_code(tap),
		.channel_select_ff(chan), .conversion_done_irq_ff(irq));
	sacc_afe_model sacc_afe_model_i (.aclk(aclk), .hold_ff(hold),
		.tap_code(tap), .channel_select_ff(chan), .slow(slow),
		.comparator_ge(cmp));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// counts stored results
	always @(posedge aclk)
		if (irq === 1'b1)
			irq_cnt <= irq_cnt + 1;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		rdr(a);
		check(rd & m, exp);
	endtask

	// waits for one stored result, bounded
	task automatic wait_irq;
		int s;
		s = irq_cnt;
		for (int i = 0; i < 300 && irq_cnt == s; i++)
			@(posedge aclk);
		if (irq_cnt == s)
			check(irq_cnt, s + 1);
		repeat (2) @(posedge aclk);
	endtask

	task automatic final_report;
		$display("counts: %0d comparisons, %0d mismatches", comparisons,
			error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		final_report;
	end

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, hw_trigger, slow} = 4'h0;
		aresetn = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`SACC_OFF_CTRL, 32'hffffffff, 32'h0);
		rc(`SACC_OFF_UPPER, 32'hff, 32'hff);
		rc(`SACC_OFF_LOWER, 32'hff, 32'h0);
		rc(`SACC_OFF_STAT, 32'hf0, 32'h10);
		wr(`SACC_OFF_RESF, 32'h3ff);
		rc(`SACC_OFF_RESF, 32'hffffffff, 32'h0);
		rdr(8'h20);
		check({30'h0, resp}, {30'h0, `SACC_RESP_SLVERR});
		wr(8'h20, 32'h0);
		check({30'h0, resp}, {30'h0, `SACC_RESP_SLVERR});
		$display("reset test done");
		wr(`SACC_OFF_CTRL, 32'h2);
		repeat (100) @(posedge aclk);
		check(irq_cnt, 0);
		rc(`SACC_OFF_CTRL, 32'hf, 32'h0);
		$display("disabled run test done");
		sacc_afe_model_i.level[3] = 10'h2a5;
		wr(`SACC_OFF_CTRL, 32'h1);
		rc(`SACC_OFF_STAT, 32'hf0, 32'h20);
		repeat (`SACC_STAB_CYC) @(posedge aclk);
		rc(`SACC_OFF_STAT, 32'h4, 32'h4);
		wr(`SACC_OFF_CHAN, 32'h3);
		wr(`SACC_OFF_CTRL, 32'h3);
		wait_irq;
		check(chan, 3);
		rc(`SACC_OFF_RESF, 32'hffff, 32'h2a5);
		rc(`SACC_OFF_RESN, 32'hff, 32'ha9);
		rc(`SACC_OFF_CTRL, 32'hf, 32'h1);
		rc(`SACC_OFF_STAT, 32'hf0, 32'h20);
		@(posedge aclk);
		hw_trigger <= 1'b1;
		repeat (4) @(posedge aclk);
		hw_trigger <= 1'b0;
		repeat (150) @(posedge aclk);
		check(irq_cnt, 1);
		$display("one-shot test done");
		wr(`SACC_OFF_CTRL, 32'hb);
		repeat (40) @(posedge aclk);
		check(irq_cnt, 1);
		hw_trigger <= 1'b1;
		repeat (4) @(posedge aclk);
		hw_trigger <= 1'b0;
		wait_irq;
		check(irq_cnt, 2);
		rc(`SACC_OFF_CTRL, 32'hf, 32'hb);
		rc(`SACC_OFF_STAT, 32'hf0, 32'h20);
		$display("hardware trigger test done");
		wr(`SACC_OFF_CTRL, 32'h3);
		repeat (30) @(posedge aclk);
		sacc_afe_model_i.level[3] = 10'h155;
		wr(`SACC_OFF_CTRL, 32'h3);
		wait_irq;
		rc(`SACC_OFF_RESF, 32'h3ff, 32'h155);
		check(irq_cnt, 3);
		sacc_afe_model_i.level[5] = 10'h0f0;
		wr(`SACC_OFF_CTRL, 32'h3);
		repeat (30) @(posedge aclk);
		wr(`SACC_OFF_CHAN, 32'h5);
		wait_irq;
		check(chan, 5);
		rc(`SACC_OFF_RESF, 32'h3ff, 32'h0f0);
		check(irq_cnt, 4);
		wr(`SACC_OFF_CTRL, 32'h3);
		repeat (30) @(posedge aclk);
		wr(`SACC_OFF_CTRL, 32'h1);
		repeat (100) @(posedge aclk);
		check(irq_cnt, 4);
		rc(`SACC_OFF_STAT, 32'hf0, 32'h20);
		rc(`SACC_OFF_RESF, 32'h3ff, 32'h0f0);
		$display("abort test done");
		sacc_afe_model_i.level[5] = 10'h000;
		wr(`SACC_OFF_LOWER, 32'h10);
		wr(`SACC_OFF_UPPER, 32'h40);
		wr(`SACC_OFF_CTRL, 32'h3);
		repeat (150) @(posedge aclk);
		check(irq_cnt, 4);
		rc(`SACC_OFF_RESF, 32'h3ff, 32'h0f0);
		rc(`SACC_OFF_CTRL, 32'hf, 32'h1);
		wr(`SACC_OFF_RANGE, 32'h1);
		wr(`SACC_OFF_CTRL, 32'h3);
		wait_irq;
		rc(`SACC_OFF_RESF, 32'h3ff, 32'h000);
		$display("window test done");
		slow <= 1'b1;
		sacc_afe_model_i.level[5] = 10'h3c3;
		wr(`SACC_OFF_CTRL, 32'h7);
		wait_irq;
		wait_irq;
		rc(`SACC_OFF_CTRL, 32'hf, 32'h7);
		rc(`SACC_OFF_RESF, 32'h3ff, 32'h3c3);
		wr(`SACC_OFF_CTRL, 32'h5);
		repeat (2) @(posedge aclk);
		c0 = irq_cnt;
		repeat (150) @(posedge aclk);
		check(irq_cnt, c0);
		wr(`SACC_OFF_CTRL, 32'h0);
		rc(`SACC_OFF_STAT, 32'hf0, 32'h10);
		$display("sequential test done");
		final_report;
	end
endmodule // tb
